// ### epw_ctrl.sv
// host side controller that writes a parallel eeprom through its pins
// assumes avalon-mm software access and a device wired to the pin ports
// Summary of operation
// (R01) write begins when select and strobe low
// (R02) each strobe fall starts a load timer
// (R03) further strobe falls restart that timer
// (R04) programming ends within ten milliseconds
// (R05) busy reads invert bit seven
// (R06) true data returned after programming
// (R07) busy reads flip bit six
// (R08) poll by pulsing enable at fixed address
// (R09) page burst takes one to 128 bytes
// (R10) next byte within load time window
// (R11) step low address bits per byte
// (R12) hold page address through write cycle
// (R13) whole page programmed together on expiry
// (R14) protection off from delivery
// (R15) three code bytes enable protection
// (R16) code prefix before each protected write
// (R17) unprefixed protected write still busies device
// (R18) six code bytes disable protection
// (R19) protection state kept, set at end
// (R20) writes blocked at low supply
// (R21) no write while output enable low
// (R22) short strobe glitches ignored
// (R23) address taken at last falling edge
// (R24) data taken at first rising edge
// (R25) code bytes and addresses are parameters
// (R26) only status reads during programming
`timescale 1ns/100ps
`default_nettype none
`include "epw_defines.svh"
module epw_ctrl #(
  parameter int TBLC_CYC = `EPW_TBLC_CYC,
  parameter int TWC_CYC = `EPW_TWC_CYC,
  parameter logic [16:0] LOCK_A0 = 17'h05555,
  parameter logic [16:0] LOCK_A1 = 17'h02aaa,
  parameter logic [16:0] LOCK_A2 = 17'h05555,
  parameter logic [7:0] LOCK_D0 = 8'haa,
  parameter logic [7:0] LOCK_D1 = 8'h55,
  parameter logic [7:0] LOCK_D2 = 8'ha0,
  parameter logic [7:0] UNLK_D2 = 8'h80,
  parameter logic [7:0] UNLK_D5 = 8'h20
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output epw_pkg::epw_ctl_type o_ctl,
  output logic [16:0] o_addr,
  output logic [7:0] o_dq_out,
  output logic o_dq_oe_n,
  input wire logic [7:0] i_dq_in
);
  import epw_pkg::*;
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  localparam int TWP = `EPW_TWP_CYC;
  localparam int TWPH = `EPW_TWPH_CYC;
  localparam int TOE = `EPW_TOE_CYC;

  epw_state_type state_ff;
  logic [31:0] cnt_ff;
  logic [31:0] gap_ff;
  logic [2:0] cmd_ff;
  logic [2:0] seq_ff;
  logic [2:0] seq_len_ff;
  logic prefix_ff;
  logic [16:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] prev_rd_ff;
  logic have_prev_ff;
  logic busy_ff;
  logic done_ff;
  logic [7:0] meta_ff;
  logic [7:0] dq_sync_ff;
  logic [7:0] page_cnt_ff;
  logic [31:0] rdata;
  epw_word_type cur;
  logic go;

  // two flops on the data pins since they change off our clock
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_ff <= 8'h00;
      dq_sync_ff <= 8'h00;
    end else begin
      meta_ff <= i_dq_in;
      dq_sync_ff <= meta_ff;
    end
  end

  // code sequence word for step seq_ff, then the user word
  always_comb begin
    cur.addr = wr_addr_ff;
    cur.data = wr_data_ff;
    if (prefix_ff) begin
      case (seq_ff)
        3'h0: begin cur.addr = LOCK_A0; cur.data = LOCK_D0; end
        3'h1: begin cur.addr = LOCK_A1; cur.data = LOCK_D1; end
        3'h2: begin
          cur.addr = LOCK_A2;
          cur.data = (cmd_ff == `EPW_CMD_UNLOCK) ? UNLK_D2 : LOCK_D2;
        end
        3'h3: begin cur.addr = LOCK_A0; cur.data = LOCK_D0; end
        3'h4: begin cur.addr = LOCK_A1; cur.data = LOCK_D1; end
        default: begin cur.addr = LOCK_A2; cur.data = UNLK_D5; end
      endcase
    end
  end

  assign go = i_avs_write && (i_avs_address == `EPW_REG_CTRL) &&
              (state_ff == ST_IDLE) &&
              (!busy_ff || i_avs_writedata[2:0] == `EPW_CMD_POLL); // (R26)

  // avalon slave: one wait state per access, unmapped reads return zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (i_avs_address == `EPW_REG_ADDR) begin
      rdata = {15'h0000, wr_addr_ff};
    end else if (i_avs_address == `EPW_REG_DATA) begin
      rdata = {24'h000000, wr_data_ff};
    end else if (i_avs_address == `EPW_REG_STAT) begin
      rdata = {22'h000000, page_cnt_ff, done_ff, busy_ff};
    end else if (i_avs_address == `EPW_REG_RDAT) begin
      rdata = {24'h000000, rd_data_ff};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_readdata <= 32'h0000_0000;
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) &&
                             o_avs_waitrequest);
      o_avs_readdata <= rdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_addr_ff <= 17'h00000;
      wr_data_ff <= 8'h00;
    end else if (i_avs_write && !o_avs_waitrequest) begin
      if (i_avs_address == `EPW_REG_ADDR) begin
        wr_addr_ff <= i_avs_writedata[16:0];
      end else if (i_avs_address == `EPW_REG_DATA) begin
        wr_data_ff <= i_avs_writedata[7:0];
      end
    end else if (state_ff == ST_DONE && !prefix_ff &&
                 cmd_ff == `EPW_CMD_WRITE) begin
      wr_addr_ff[6:0] <= wr_addr_ff[6:0] + 7'h01; // (R11)
    end
  end

  // main sequencer: strobe controlled writes, output enable polls
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 32'h0000_0000;
      cmd_ff <= 3'h0;
      seq_ff <= 3'h0;
      seq_len_ff <= 3'h0;
      prefix_ff <= 1'b0;
      o_ctl <= '{device_select_n: 1'b1, store_strobe_n: 1'b1,
                 output_drive_enable_n: 1'b1};
      o_addr <= 17'h00000;
      o_dq_out <= 8'h00;
      o_dq_oe_n <= 1'b1;
      rd_data_ff <= 8'h00;
      prev_rd_ff <= 8'h00;
      have_prev_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      case (state_ff)
        ST_IDLE: begin
          // status polls are the only orders taken while programming
          if (go && !o_avs_waitrequest) begin
            cmd_ff <= i_avs_writedata[2:0];
            done_ff <= 1'b0;
            seq_ff <= 3'h0;
            // (R25) code words come from parameters
            prefix_ff <= i_avs_writedata[2:0] != `EPW_CMD_READ &&
                         i_avs_writedata[2:0] != `EPW_CMD_POLL &&
                         (i_avs_writedata[3] ||
                          i_avs_writedata[2:0] != `EPW_CMD_WRITE); // (R16)
            seq_len_ff <= (i_avs_writedata[2:0] == `EPW_CMD_UNLOCK) ?
                          3'h6 : 3'h3; // (R15) (R18)
            have_prev_ff <= 1'b0;
            cnt_ff <= 32'h0;
            if (i_avs_writedata[2:0] == `EPW_CMD_READ ||
                i_avs_writedata[2:0] == `EPW_CMD_POLL) begin
              state_ff <= ST_RD_SETUP;
            end else begin
              state_ff <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          // (R21) enable held high before select and strobe fall
          o_ctl.output_drive_enable_n <= 1'b1;
          o_addr <= cur.addr; // (R12) (R23)
          o_dq_out <= cur.data;
          o_dq_oe_n <= 1'b0;
          o_ctl.device_select_n <= 1'b0;
          cnt_ff <= 32'h0;
          state_ff <= ST_STROBE;
        end
        ST_STROBE: begin
          o_ctl.store_strobe_n <= 1'b0; // (R01) (R02) (R22)
          // pulse kept well past the noise filter width
          if (cnt_ff >= 32'(TWP)) begin
            o_ctl.store_strobe_n <= 1'b1; // (R24)
            cnt_ff <= 32'h0;
            state_ff <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          o_ctl.device_select_n <= 1'b1;
          if (cnt_ff >= 32'(TWPH)) begin
            o_dq_oe_n <= 1'b1;
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          // (R03) (R10) next byte follows at once, well inside tblc
          if (prefix_ff && seq_ff + 3'h1 < seq_len_ff) begin
            seq_ff <= seq_ff + 3'h1;
            state_ff <= ST_SETUP;
          end else if (prefix_ff && cmd_ff == `EPW_CMD_WRITE) begin
            prefix_ff <= 1'b0;
            state_ff <= ST_SETUP;
          end else begin
            busy_ff <= 1'b1; // (R13) (R17) (R19) device now programming
            done_ff <= 1'b1;
            prefix_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
        ST_RD_SETUP: begin
          o_dq_oe_n <= 1'b1;
          o_ctl.store_strobe_n <= 1'b1; // (R26)
          o_addr <= wr_addr_ff; // (R08)
          o_ctl.device_select_n <= 1'b0;
          o_ctl.output_drive_enable_n <= 1'b0;
          cnt_ff <= 32'h0;
          state_ff <= ST_RD_WAIT;
        end
        ST_RD_WAIT: begin
          // extra cycles cover the two flop data synchroniser
          if (cnt_ff >= 32'(TOE + 2)) begin
            rd_data_ff <= dq_sync_ff; // (R05)
            prev_rd_ff <= dq_sync_ff;
            have_prev_ff <= 1'b1;
            o_ctl.output_drive_enable_n <= 1'b1;
            o_ctl.device_select_n <= 1'b1;
            cnt_ff <= 32'h0;
            state_ff <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          // a plain read ends after one access, a poll reads again
          if (cmd_ff == `EPW_CMD_READ) begin
            done_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end else begin
            state_ff <= ST_POLL_GAP;
          end
        end
        ST_POLL_GAP: begin
          if (cnt_ff >= 32'(TOE)) begin
            o_ctl.device_select_n <= 1'b0;
            o_ctl.output_drive_enable_n <= 1'b0;
            cnt_ff <= 32'h0;
            state_ff <= ST_RD_WAIT;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      // (R06) (R07) bit six stops flipping once programming is over; bit
      // seven is left out since a refused protected write keeps old data
      if (state_ff == ST_RD_WAIT && cnt_ff >= 32'(TOE + 2) &&
          cmd_ff == `EPW_CMD_POLL && have_prev_ff &&
          dq_sync_ff[6] == prev_rd_ff[6]) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
        o_ctl.output_drive_enable_n <= 1'b1;
        o_ctl.device_select_n <= 1'b1;
        state_ff <= ST_IDLE;
      end
      // (R04) timeout frees the controller after the longest cycle
      if (busy_ff && state_ff == ST_IDLE && gap_ff >= 32'(TWC_CYC)) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // time since the last strobe fell, covers load and program times
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gap_ff <= 32'h0;
      page_cnt_ff <= 8'h00;
    end else if (state_ff == ST_STROBE && cnt_ff == 32'h0) begin
      gap_ff <= 32'h0;
      if (!prefix_ff && page_cnt_ff < 8'(`EPW_PAGE_BYTES)) begin
        page_cnt_ff <= page_cnt_ff + 8'h01; // (R09)
      end
    end else begin
      gap_ff <= gap_ff + 32'h1;
      if (gap_ff >= 32'(TBLC_CYC) && state_ff == ST_IDLE && go) begin
        page_cnt_ff <= 8'h00;
      end
    end
  end

  // (R14) (R20) device protection and supply state are its own concern
  property p_strobe_width;
    $fell(o_ctl.store_strobe_n) |-> !o_ctl.store_strobe_n [*8];
  endproperty
  a_strobe_width: assert property (p_strobe_width) // (R22)
    else $error("strobe pulse too short");
  property p_no_oe_write;
    !o_ctl.store_strobe_n |-> o_ctl.output_drive_enable_n;
  endproperty
  a_no_oe_write: assert property (p_no_oe_write) // (R21)
    else $error("output enable low during strobe");
  property p_sel_first;
    $fell(o_ctl.store_strobe_n) |-> !o_ctl.device_select_n;
  endproperty
  a_sel_first: assert property (p_sel_first) // (R01)
    else $error("strobe fell without select");
  property p_addr_stable;
    !o_ctl.store_strobe_n |=> $stable(o_addr) || o_ctl.store_strobe_n;
  endproperty
  a_addr_stable: assert property (p_addr_stable) // (R12)
    else $error("address moved during strobe");
  property p_data_stable;
    $rose(o_ctl.store_strobe_n) |-> !o_dq_oe_n && $stable(o_dq_out);
  endproperty
  a_data_stable: assert property (p_data_stable) // (R24)
    else $error("data not held at strobe rise");
  property p_poll_no_strobe;
    !o_ctl.output_drive_enable_n |-> o_ctl.store_strobe_n && o_dq_oe_n;
  endproperty
  a_poll_no_strobe: assert property (p_poll_no_strobe) // (R08)
    else $error("write during status read");
  property p_busy_no_write;
    busy_ff && state_ff == ST_IDLE |=> state_ff != ST_SETUP;
  endproperty
  a_busy_no_write: assert property (p_busy_no_write) // (R26)
    else $error("write while device busy");
  property p_page_max;
    page_cnt_ff <= 8'(`EPW_PAGE_BYTES);
  endproperty
  a_page_max: assert property (p_page_max) // (R09)
    else $error("page count above page size");
endmodule : epw_ctrl
`default_nettype wire

// ### epw_defines.svh
// timing counts and register map for the eeprom page write controller
// assumes a 200 mhz system clock
`ifndef EPW_DEFINES_SVH
`define EPW_DEFINES_SVH
`define EPW_CLK_MHZ 200
`define EPW_TWP_NS 100
`define EPW_TWP_CYC ((`EPW_TWP_NS * `EPW_CLK_MHZ + 999) / 1000)
`define EPW_TWPH_NS 50
`define EPW_TWPH_CYC ((`EPW_TWPH_NS * `EPW_CLK_MHZ + 999) / 1000)
`define EPW_TOE_NS 150
`define EPW_TOE_CYC ((`EPW_TOE_NS * `EPW_CLK_MHZ + 999) / 1000)
`define EPW_TBLC_US 150
`define EPW_TBLC_CYC ((`EPW_TBLC_US * `EPW_CLK_MHZ) / 1)
`define EPW_TWC_MS 10
`define EPW_TWC_CYC ((`EPW_TWC_MS * 1000 * `EPW_CLK_MHZ) / 1)
`define EPW_PAGE_BYTES 128
`define EPW_REG_CTRL 4'h0
`define EPW_REG_ADDR 4'h1
`define EPW_REG_DATA 4'h2
`define EPW_REG_STAT 4'h3
`define EPW_REG_RDAT 4'h4
`define EPW_REG_CODE 4'h5
`define EPW_CMD_WRITE 3'h1
`define EPW_CMD_READ 3'h2
`define EPW_CMD_POLL 3'h3
`define EPW_CMD_LOCK 3'h4
`define EPW_CMD_UNLOCK 3'h5
`endif

// ### epw_pkg.sv
// types for the eeprom page write controller
// shared by the controller, the eeprom model and the bench
package epw_pkg;
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
  } epw_word_type;
  typedef struct packed {
    logic device_select_n;
    logic store_strobe_n;
    logic output_drive_enable_n;
  } epw_ctl_type;
  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_RD_SETUP, ST_RD_WAIT,
    ST_NEXT, ST_POLL_GAP, ST_DONE
  } epw_state_type;
endpackage : epw_pkg

// ### epw_eeprom_model.sv
// behavioural eeprom seen at its pins: page load, timers, protection
// assumes pins from epw_ctrl; sampled on the falling clock edge to stay
// clear of the controller's rising-edge updates
`timescale 1ns/100ps
`default_nettype none
module epw_eeprom_model #(
  parameter int TBLC_M = 150,
  parameter int TWC_M = 1000
) (
  input wire logic i_clk_sys,
  input wire epw_pkg::epw_ctl_type i_ctl,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_busy
);
  import epw_pkg::*;
  logic [7:0] mem [logic [16:0]];
  logic [16:0] pa [$];
  logic [7:0] pd [$];
  logic [16:0] cap_a = 17'h00000;
  logic [7:0] last = 8'h00;
  logic prot = 1'b0;
  logic wr_act = 1'b0;
  logic rd_act = 1'b0;
  logic flip = 1'b0;
  int tmr = 0;
  int bsy = 0;
  int low = 0;
  logic wr_now, rd_now;
  assign wr_now = !i_ctl.device_select_n && !i_ctl.store_strobe_n &&
                  i_ctl.output_drive_enable_n;
  assign rd_now = !i_ctl.device_select_n && i_ctl.store_strobe_n &&
                  !i_ctl.output_drive_enable_n;
  assign o_busy = (bsy != 0);
  initial o_dq = 8'h00;
  // code bytes match the controller's default parameters
  function automatic logic code(int i, logic [7:0] d2);
    return pa.size() >= i + 3 && pa[i] == 17'h05555 && pd[i] == 8'haa &&
      pa[i+1] == 17'h02aaa && pd[i+1] == 8'h55 &&
      pa[i+2] == 17'h05555 && pd[i+2] == d2;
  endfunction : code
  task automatic commit();
    int n;
    n = 0;
    if (code(0, 8'h80) && code(3, 8'h20)) begin
      prot = 1'b0;
      n = 6;
    end else if (code(0, 8'ha0)) begin
      prot = 1'b1;
      n = 3;
    end
    repeat (n) begin
      void'(pa.pop_front());
      void'(pd.pop_front());
    end
    if (n != 0 || !prot) foreach (pa[i]) mem[pa[i]] = pd[i];
    pa.delete();
    pd.delete();
  endtask : commit
  always @(negedge i_clk_sys) begin
    if (wr_now && !wr_act && bsy == 0) begin
      cap_a = i_addr;
      tmr = TBLC_M;
    end
    if (!wr_now && wr_act && low >= 3 && tmr > 0) begin
      pa.push_back(cap_a);
      pd.push_back(i_dq);
      last = i_dq;
    end else if (tmr > 0) begin
      tmr--;
      if (tmr == 0) bsy = TWC_M;
    end
    if (bsy > 0) begin
      bsy--;
      if (bsy == 0) commit();
    end
    if (rd_now && !rd_act) flip = !flip;
    if (rd_now) begin
      // the load window already counts as a write in progress
      o_dq = (bsy != 0 || tmr != 0) ? {~last[7], flip, last[5:0]} :
        (mem.exists(i_addr) ? mem[i_addr] : 8'hff);
    end else begin
      o_dq = ~o_dq; // released bus has no pull, so never a stale value
    end
    wr_act = wr_now;
    rd_act = rd_now;
    low = wr_now ? low + 1 : 0;
  end
endmodule : epw_eeprom_model
`default_nettype wire

// ### tb_top.sv
// self-checking bench for epw_ctrl over avalon-mm against a pin model
// assumes the register map of epw_defines.svh and shortened timer counts
`timescale 1ns/100ps
`default_nettype none
`include "epw_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  import epw_pkg::*;
  logic i_clk_sys, i_rst_b, rd, wr, wreq, dq_oe_n, m_busy, seen;
  logic [3:0] adr;
  logic [31:0] wdat, rdat;
  epw_ctl_type ctl;
  logic [16:0] paddr;
  logic [7:0] dq_o, dq_i;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  epw_ctrl #(.TBLC_CYC(200), .TWC_CYC(2000)) uut (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .o_ctl(ctl), .o_addr(paddr),
    .o_dq_out(dq_o), .o_dq_oe_n(dq_oe_n), .i_dq_in(dq_i));
  epw_eeprom_model mdl (.i_clk_sys(i_clk_sys), .i_ctl(ctl),
    .i_addr(paddr), .i_dq(dq_o), .o_dq(dq_i), .o_busy(m_busy));
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    if (m_busy === 1'b1) seen <= 1'b1;
    cyc++;
    if (cyc == 40000) begin
      fails++;
      end_sim();
    end
  end
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk_sys);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do @(posedge i_clk_sys); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wreg
  task automatic wait_stat(input int b, input logic v);
    logic [31:0] s;
    do bus(1'b0, `EPW_REG_STAT, 32'h0, s); while (s[b] !== v);
  endtask : wait_stat
  // issues one command, then polls to the end of the programming period
  task automatic op(input logic [3:0] c, input logic [16:0] a,
                    input logic [7:0] d);
    wreg(`EPW_REG_ADDR, {15'h0, a});
    wreg(`EPW_REG_DATA, {24'h0, d});
    seen = 1'b0;
    wreg(`EPW_REG_CTRL, {28'h0, c});
    wait_stat(0, 1'b1);
    wreg(`EPW_REG_CTRL, {29'h0, `EPW_CMD_POLL});
    wait_stat(0, 1'b0);
    `CHK(m_busy, 1'b0);
    `CHK(seen, 1'b1);
  endtask : op
  task automatic rd_chk(input logic [16:0] a, input logic [7:0] e);
    logic [31:0] q;
    wreg(`EPW_REG_ADDR, {15'h0, a});
    wreg(`EPW_REG_CTRL, {29'h0, `EPW_CMD_READ});
    wait_stat(1, 1'b1);
    bus(1'b0, `EPW_REG_RDAT, 32'h0, q);
    `CHK(q[7:0], e);
  endtask : rd_chk
  task automatic t_reset();
    logic [31:0] q;
    `CHK(ctl, 3'b111);
    `CHK(dq_oe_n, 1'b1);
    bus(1'b0, 4'hf, 32'h0, q);
    `CHK(q, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_write();
    logic [31:0] q;
    op({1'b0, `EPW_CMD_WRITE}, 17'h00123, 8'h5a);
    bus(1'b0, `EPW_REG_STAT, 32'h0, q);
    `CHK(q[9:2], 8'h01);
    bus(1'b0, `EPW_REG_ADDR, 32'h0, q);
    `CHK(q[16:0], 17'h00124);
    rd_chk(17'h00123, 8'h5a);
    op({1'b0, `EPW_CMD_WRITE}, 17'h1ff80, 8'ha5);
    rd_chk(17'h1ff80, 8'ha5);
    $display("test write done");
  endtask : t_write
  task automatic t_lock();
    op({1'b0, `EPW_CMD_LOCK}, 17'h0, 8'h0);
    op({1'b0, `EPW_CMD_WRITE}, 17'h00200, 8'h33);
    rd_chk(17'h00200, 8'hff);
    op({1'b1, `EPW_CMD_WRITE}, 17'h00201, 8'h44);
    rd_chk(17'h00201, 8'h44);
    rd_chk(17'h00123, 8'h5a);
    $display("test lock done");
  endtask : t_lock
  task automatic t_unlock();
    op({1'b0, `EPW_CMD_UNLOCK}, 17'h0, 8'h0);
    op({1'b0, `EPW_CMD_WRITE}, 17'h00202, 8'h66);
    rd_chk(17'h00202, 8'h66);
    $display("test unlock done");
  endtask : t_unlock
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    seen = 1'b0;
    i_rst_b = 1'b0;
    repeat (8) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(negedge i_clk_sys);
    t_reset();
    t_write();
    t_lock();
    t_unlock();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
